// >>> include/pts_pkg.sv
// Shared constants and types of the page timeout and scan enable block.
package pts_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_PS = 25000;
	localparam int unsigned SLOT_TIME_PS  = 625000000;
	localparam int unsigned SLOT_CYC      = SLOT_TIME_PS / CLK_PERIOD_PS;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CMD      = 8'h00;
	localparam logic [7:0] OFS_RESULT   = 8'h04;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
	localparam logic [7:0] OFS_PAGE_CTL = 8'h10;
	localparam logic [7:0] OFS_PSCAN    = 8'h14;
	localparam logic [7:0] OFS_ISCAN    = 8'h18;
	localparam logic [7:0] OFS_STATE    = 8'h1c;

	// ------------------------------------------------------------
	// Command codes
	// ------------------------------------------------------------
	localparam logic [9:0] OCF_WR_CONN_ACC = 10'h016;
	localparam logic [9:0] OCF_RD_PAGE_TO  = 10'h017;
	localparam logic [9:0] OCF_WR_PAGE_TO  = 10'h018;
	localparam logic [9:0] OCF_RD_SCAN     = 10'h019;
	localparam logic [9:0] OCF_WR_SCAN     = 10'h01a;

	// ------------------------------------------------------------
	// Status codes and field layout
	// ------------------------------------------------------------
	localparam logic [7:0] ST_OK          = 8'h00;
	localparam logic [7:0] ST_UNKNOWN_CMD = 8'h01;
	localparam logic [7:0] ST_BAD_PARAM   = 8'h12;
	localparam int unsigned IRQ_CMD_DONE  = 0;
	localparam int unsigned IRQ_PAGE_FAIL = 1;
	localparam int unsigned IRQ_PAGE_OK   = 2;
	localparam int unsigned IRQ_W         = 3;
	localparam int unsigned PG_START_BIT  = 0;
	localparam int unsigned PG_ABORT_BIT  = 1;

	// ------------------------------------------------------------
	// Reset values and limits
	// ------------------------------------------------------------
	localparam logic [15:0] PAGE_TO_RST  = 16'h2000;
	localparam logic [1:0]  SCAN_EN_RST  = 2'h0;
	localparam logic [15:0] SCAN_INT_RST = 16'h0800;
	localparam logic [15:0] SCAN_WIN_RST = 16'h0012;
	localparam logic [15:0] SCAN_MIN     = 16'h0012;
	localparam logic [15:0] SCAN_MAX     = 16'h1000;
	localparam logic [1:0]  SCAN_INQ_BIT = 2'h1;
	localparam logic [1:0]  SCAN_PG_BIT  = 2'h2;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] window;
		logic [15:0] interval;
	} pts_act_t;

	typedef struct packed {
		logic [15:0] param;
		logic [5:0]  pad;
		logic [9:0]  ocf;
	} pts_cmd_t;

	typedef enum logic [1:0] {
		PG_IDLE = 2'b01,
		PG_RUN  = 2'b10
	} pts_page_st_t;

endpackage

// >>> src/pts_scan_sched.sv
// Periodic scan scheduler driven by baseband slot ticks.
`timescale 1ns/1ps
module pts_scan_sched (
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             enable_in,
	input  wire logic             tick_in,
	input  wire pts_pkg::pts_act_t act_in,
	output logic                  active_out
);

	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	logic        active_nxt;
	wire         wrap = (cnt_r >= act_in.interval - 16'h0001);

	// Counts slots from the start of one scan to the next.
	assign cnt_nxt    = !enable_in ? 16'h0000 :
	                    !tick_in ? cnt_r :
	                    wrap ? 16'h0000 : cnt_r + 16'h0001;
	assign active_nxt = enable_in && (cnt_nxt < act_in.window);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_r      <= 16'h0000;
			active_out <= 1'b0;
		end else begin
			cnt_r      <= cnt_nxt;
			active_out <= active_nxt;
		end
	end

endmodule

// >>> src/pts_page_timer.sv
// Page attempt timer that fails the attempt when the slot count runs out.
`timescale 1ns/1ps
module pts_page_timer (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        start_in,
	input  wire logic        abort_in,
	input  wire logic        resp_in,
	input  wire logic        tick_in,
	input  wire logic [15:0] limit_in,
	output logic             busy_out,
	output logic             ok_out,
	output logic             fail_out
);

	pts_pkg::pts_page_st_t st_r;
	pts_pkg::pts_page_st_t st_nxt;
	logic [15:0]           left_r;
	logic [15:0]           left_nxt;
	wire                   run     = (st_r == pts_pkg::PG_RUN);
	wire                   got     = run && resp_in;
	wire                   expired = run && !resp_in && tick_in &&
	                                 (left_r == 16'h0001);

	always_comb begin
		st_nxt   = st_r;
		left_nxt = left_r;
		case (st_r)
			pts_pkg::PG_IDLE: begin
				if (start_in) begin
					st_nxt   = pts_pkg::PG_RUN;
					left_nxt = limit_in;
				end
			end
			pts_pkg::PG_RUN: begin
				if (got || expired || abort_in) begin
					st_nxt = pts_pkg::PG_IDLE;
				end else if (tick_in) begin
					left_nxt = left_r - 16'h0001;
				end
			end
			default: begin
				st_nxt = pts_pkg::PG_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_r     <= pts_pkg::PG_IDLE;
			left_r   <= 16'h0000;
			busy_out <= 1'b0;
			ok_out   <= 1'b0;
			fail_out <= 1'b0;
		end else begin
			st_r     <= st_nxt;
			left_r   <= left_nxt;
			busy_out <= (st_nxt == pts_pkg::PG_RUN);
			ok_out   <= got;
			fail_out <= expired;
		end
	end

endmodule

// >>> src/pts_top.sv
// Command handler for page timeout and scan enable with an Avalon-MM slave.
//
// Notes on behaviour
// - Each command answers with a status byte, zero for success and nonzero for an error code.
// - Each finished command raises a command complete event unless the event is masked.
// - The write connection accept timeout command answers with a single status byte.
// - Code 0x0017 reads the page timeout and answers status and the stored value.
// - Code 0x0018 writes the page timeout from its parameter and answers only status.
// - The page timeout counts baseband slots of 0.625 ms for a locally started page.
// - A page that sees no response before the timeout runs out is reported as failed.
// - The stored page timeout is 0x2000 slots after reset.
// - Code 0x0019 reads the scan enable and answers status and the one-byte value.
// - Code 0x001a writes the scan enable and answers only status.
// - Scan enable 0 is off, 1 inquiry only, 2 page only, 3 both, and 0 after reset.
// - With page scan on, page scans repeat by the page scan interval and window.
// - With inquiry scan on, inquiry scans repeat by their own interval and window.
// - The interval runs from one scan start to the next and the window is the scan length.
//
// Local design decisions: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
module pts_top #(
	parameter int unsigned SLOT_CYC = pts_pkg::SLOT_CYC
) (
	input  wire logic        CLK_IN,
	input  wire logic        RST_N_IN,
	input  wire logic [7:0]  AVS_ADDRESS_IN,
	input  wire logic        AVS_READ_IN,
	input  wire logic        AVS_WRITE_IN,
	input  wire logic [31:0] AVS_WRITEDATA_IN,
	input  wire logic [3:0]  AVS_BYTEENABLE_IN,
	output logic [31:0]      AVS_READDATA_OUT,
	output logic             AVS_WAITREQUEST_OUT,
	input  wire logic        PAGE_RESP_IN,
	output logic             PAGE_SCAN_OUT,
	output logic             INQ_SCAN_OUT,
	output logic             PAGING_OUT,
	output logic             IRQ_OUT
);

	// ------------------------------------------------------------
	// Bus handshake and decode
	// ------------------------------------------------------------
	wire        req     = AVS_READ_IN || AVS_WRITE_IN;
	wire        fetch   = AVS_READ_IN && AVS_WAITREQUEST_OUT;
	wire        commit  = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT;
	wire [31:0] be_mask = {{8{AVS_BYTEENABLE_IN[3]}},
	                       {8{AVS_BYTEENABLE_IN[2]}},
	                       {8{AVS_BYTEENABLE_IN[1]}},
	                       {8{AVS_BYTEENABLE_IN[0]}}};
	wire [31:0] wdata   = AVS_WRITEDATA_IN & be_mask;
	wire        sel_cmd  = (AVS_ADDRESS_IN == pts_pkg::OFS_CMD);
	wire        sel_res  = (AVS_ADDRESS_IN == pts_pkg::OFS_RESULT);
	wire        sel_stat = (AVS_ADDRESS_IN == pts_pkg::OFS_IRQ_STAT);
	wire        sel_mask = (AVS_ADDRESS_IN == pts_pkg::OFS_IRQ_MASK);
	wire        sel_pctl = (AVS_ADDRESS_IN == pts_pkg::OFS_PAGE_CTL);
	wire        sel_psc  = (AVS_ADDRESS_IN == pts_pkg::OFS_PSCAN);
	wire        sel_isc  = (AVS_ADDRESS_IN == pts_pkg::OFS_ISCAN);
	wire        sel_st   = (AVS_ADDRESS_IN == pts_pkg::OFS_STATE);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	pts_pkg::pts_cmd_t            cmd_r;
	logic [7:0]                   status_r;
	logic [15:0]                  ret_r;
	logic [15:0]                  page_to_r;
	logic [1:0]                   scan_en_r;
	logic [pts_pkg::IRQ_W-1:0]    stat_r;
	logic [pts_pkg::IRQ_W-1:0]    mask_r;
	logic [pts_pkg::IRQ_W-1:0]    stat_nxt;
	pts_pkg::pts_act_t            pact_r;
	pts_pkg::pts_act_t            iact_r;
	logic                         resp_s1_r;
	logic                         resp_s2_r;
	logic [15:0]                  slot_cnt_r;
	logic                         tick_r;
	logic                         page_ok;
	logic                         page_fail;

	// ------------------------------------------------------------
	// Command execution
	// ------------------------------------------------------------
	pts_pkg::pts_cmd_t cmd_in;
	logic [7:0]        ex_status;
	logic [15:0]       ex_ret;
	logic              ex_pto_wr;
	logic              ex_scan_wr;
	wire               cmd_go = commit && sel_cmd;

	assign cmd_in = wdata;

	always_comb begin
		ex_status  = pts_pkg::ST_OK;
		ex_ret     = 16'h0000;
		ex_pto_wr  = 1'b0;
		ex_scan_wr = 1'b0;
		case (cmd_in.ocf)
			pts_pkg::OCF_WR_CONN_ACC: begin
				ex_status = pts_pkg::ST_OK;
			end
			pts_pkg::OCF_RD_PAGE_TO: begin
				ex_ret = page_to_r;
			end
			pts_pkg::OCF_WR_PAGE_TO: begin
				if (cmd_in.param == 16'h0000) begin
					ex_status = pts_pkg::ST_BAD_PARAM;
				end else begin
					ex_pto_wr = 1'b1;
				end
			end
			pts_pkg::OCF_RD_SCAN: begin
				ex_ret = {14'h0000, scan_en_r};
			end
			pts_pkg::OCF_WR_SCAN: begin
				if (cmd_in.param > 16'h0003) begin
					ex_status = pts_pkg::ST_BAD_PARAM;
				end else begin
					ex_scan_wr = 1'b1;
				end
			end
			default: begin
				ex_status = pts_pkg::ST_UNKNOWN_CMD;
			end
		endcase
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			cmd_r     <= '0;
			status_r  <= pts_pkg::ST_OK;
			ret_r     <= 16'h0000;
			page_to_r <= pts_pkg::PAGE_TO_RST;
			scan_en_r <= pts_pkg::SCAN_EN_RST;
		end else if (cmd_go) begin
			cmd_r    <= cmd_in;
			status_r <= ex_status;
			ret_r    <= ex_ret;
			if (ex_pto_wr) begin
				page_to_r <= cmd_in.param;
			end
			if (ex_scan_wr) begin
				scan_en_r <= cmd_in.param[1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Scan activity registers
	// ------------------------------------------------------------
	pts_pkg::pts_act_t act_in;
	wire               act_ok;

	assign act_in = wdata;
	assign act_ok = (act_in.interval >= pts_pkg::SCAN_MIN) &&
	                (act_in.interval <= pts_pkg::SCAN_MAX) &&
	                (act_in.window >= pts_pkg::SCAN_MIN) &&
	                (act_in.window <= act_in.interval);

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			pact_r <= {pts_pkg::SCAN_WIN_RST, pts_pkg::SCAN_INT_RST};
			iact_r <= {pts_pkg::SCAN_WIN_RST, pts_pkg::SCAN_INT_RST};
		end else begin
			if (commit && sel_psc && act_ok) begin
				pact_r <= act_in;
			end
			if (commit && sel_isc && act_ok) begin
				iact_r <= act_in;
			end
		end
	end

	// ------------------------------------------------------------
	// Slot tick and page response synchroniser
	// ------------------------------------------------------------
	wire slot_end = (slot_cnt_r == 16'(SLOT_CYC - 1));

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			slot_cnt_r <= 16'h0000;
			tick_r     <= 1'b0;
			resp_s1_r  <= 1'b0;
			resp_s2_r  <= 1'b0;
		end else begin
			slot_cnt_r <= slot_end ? 16'h0000 : slot_cnt_r + 16'h0001;
			tick_r     <= slot_end;
			resp_s1_r  <= PAGE_RESP_IN;
			resp_s2_r  <= resp_s1_r;
		end
	end

	// ------------------------------------------------------------
	// Page timer and scan schedulers
	// ------------------------------------------------------------
	wire pg_start = commit && sel_pctl && wdata[pts_pkg::PG_START_BIT];
	wire pg_abort = commit && sel_pctl && wdata[pts_pkg::PG_ABORT_BIT];

	pts_page_timer u_page_timer (
		.clk_in   (CLK_IN),
		.rst_n_in (RST_N_IN),
		.start_in (pg_start),
		.abort_in (pg_abort),
		.resp_in  (resp_s2_r),
		.tick_in  (tick_r),
		.limit_in (page_to_r),
		.busy_out (PAGING_OUT),
		.ok_out   (page_ok),
		.fail_out (page_fail)
	);

	pts_scan_sched u_page_scan (
		.clk_in     (CLK_IN),
		.rst_n_in   (RST_N_IN),
		.enable_in  (|(scan_en_r & pts_pkg::SCAN_PG_BIT)),
		.tick_in    (tick_r),
		.act_in     (pact_r),
		.active_out (PAGE_SCAN_OUT)
	);

	pts_scan_sched u_inq_scan (
		.clk_in     (CLK_IN),
		.rst_n_in   (RST_N_IN),
		.enable_in  (|(scan_en_r & pts_pkg::SCAN_INQ_BIT)),
		.tick_in    (tick_r),
		.act_in     (iact_r),
		.active_out (INQ_SCAN_OUT)
	);

	// ------------------------------------------------------------
	// Interrupt status and mask
	// ------------------------------------------------------------
	wire [pts_pkg::IRQ_W-1:0] ev;
	wire [pts_pkg::IRQ_W-1:0] clr;

	assign ev[pts_pkg::IRQ_CMD_DONE]  = cmd_go;
	assign ev[pts_pkg::IRQ_PAGE_FAIL] = page_fail;
	assign ev[pts_pkg::IRQ_PAGE_OK]   = page_ok;
	assign clr = (commit && sel_stat) ? wdata[pts_pkg::IRQ_W-1:0] : '0;
	assign stat_nxt = (stat_r & ~clr) | ev;

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			stat_r  <= '0;
			mask_r  <= '0;
			IRQ_OUT <= 1'b0;
		end else begin
			stat_r  <= stat_nxt;
			if (commit && sel_mask) begin
				mask_r <= wdata[pts_pkg::IRQ_W-1:0];
			end
			IRQ_OUT <= |(stat_r & mask_r);
		end
	end

	// ------------------------------------------------------------
	// Read data and wait request
	// ------------------------------------------------------------
	wire [31:0] rd_mux =
		sel_cmd  ? cmd_r :
		sel_res  ? {8'h00, ret_r, status_r} :
		sel_stat ? {29'h00000000, stat_r} :
		sel_mask ? {29'h00000000, mask_r} :
		sel_pctl ? {31'h00000000, PAGING_OUT} :
		sel_psc  ? pact_r :
		sel_isc  ? iact_r :
		sel_st   ? {page_to_r, 12'h000, INQ_SCAN_OUT, PAGE_SCAN_OUT,
		            scan_en_r} :
		32'h00000000;

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			AVS_READDATA_OUT    <= 32'h00000000;
			AVS_WAITREQUEST_OUT <= 1'b1;
		end else begin
			if (fetch) begin
				AVS_READDATA_OUT <= rd_mux;
			end
			AVS_WAITREQUEST_OUT <= !(req && AVS_WAITREQUEST_OUT);
		end
	end

endmodule

// >>> sim/pts_top_props.sv
// Port-level checks of the page timeout and scan enable block.
`timescale 1ns/1ps
module pts_top_props (
	input wire logic        CLK_IN,
	input wire logic        RST_N_IN,
	input wire logic [7:0]  AVS_ADDRESS_IN,
	input wire logic        AVS_READ_IN,
	input wire logic        AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	input wire logic [3:0]  AVS_BYTEENABLE_IN,
	input wire logic [31:0] AVS_READDATA_OUT,
	input wire logic        AVS_WAITREQUEST_OUT,
	input wire logic        PAGE_RESP_IN,
	input wire logic        PAGE_SCAN_OUT,
	input wire logic        INQ_SCAN_OUT,
	input wire logic        PAGING_OUT,
	input wire logic        IRQ_OUT
);
	wire wr_done = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT;
	wire pg_wr   = wr_done && AVS_ADDRESS_IN == pts_pkg::OFS_PAGE_CTL;
	wire pg_ctl  = pg_wr && AVS_BYTEENABLE_IN[0];
	wire msk_wr  = wr_done && AVS_ADDRESS_IN == pts_pkg::OFS_IRQ_MASK;
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);
	a_wait_answer: assert property (
		(AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT
		|=> !AVS_WAITREQUEST_OUT) else $error("no answer after request");
	a_wait_single: assert property (
		!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
		else $error("answer lasted too long");
	a_rdata_hold: assert property (
		!(AVS_READ_IN && AVS_WAITREQUEST_OUT) |=> $stable(AVS_READDATA_OUT))
		else $error("read data changed without a read");
	a_unmapped_zero: assert property (
		AVS_READ_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == 8'h20
		|-> AVS_READDATA_OUT == 32'h0) else $error("unmapped read not zero");
	a_irq_masked: assert property (
		msk_wr && AVS_WRITEDATA_IN == 32'h0 |-> ##2 (!IRQ_OUT)[*3])
		else $error("interrupt high while masked");
	a_page_start: assert property (
		pg_ctl && AVS_WRITEDATA_IN[1:0] == 2'h1 && !PAGING_OUT
		|=> PAGING_OUT) else $error("page did not start");
	a_page_abort: assert property (
		pg_ctl && AVS_WRITEDATA_IN[1] |-> ##[1:3] !PAGING_OUT)
		else $error("page abort ignored");
	a_page_answer: assert property (
		PAGING_OUT && PAGE_RESP_IN |-> ##[1:5] !PAGING_OUT)
		else $error("page response did not end attempt");
endmodule
bind pts_top pts_top_props u_pts_top_props (
	.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .AVS_ADDRESS_IN(AVS_ADDRESS_IN),
	.AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
	.AVS_WRITEDATA_IN(AVS_WRITEDATA_IN),
	.AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN),
	.AVS_READDATA_OUT(AVS_READDATA_OUT),
	.AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
	.PAGE_RESP_IN(PAGE_RESP_IN), .PAGE_SCAN_OUT(PAGE_SCAN_OUT),
	.INQ_SCAN_OUT(INQ_SCAN_OUT), .PAGING_OUT(PAGING_OUT), .IRQ_OUT(IRQ_OUT)
);

// >>> sim/pts_bb_model.sv
// Baseband responder that answers a running page after a set delay.
`timescale 1ns/1ps
module pts_bb_model (
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       paging_in,
	input  wire logic       answer_in,
	input  wire logic [7:0] delay_in,
	output logic            resp_out
);
	logic [7:0] wait_r;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wait_r   <= 8'h00;
			resp_out <= 1'b0;
		end else if (!paging_in) begin
			wait_r   <= 8'h00;
			resp_out <= 1'b0;
		end else if (wait_r < delay_in) begin
			wait_r <= wait_r + 8'h01;
		end else begin
			resp_out <= answer_in;
		end
	end
endmodule

// >>> sim/pts_top_tb_top.sv
// Self-checking bench of the page timeout and scan enable block.
`timescale 1ns/1ps
module pts_top_tb_top;
	logic        CLK_IN;
	logic        RST_N_IN;
	logic [7:0]  AVS_ADDRESS_IN;
	logic        AVS_READ_IN;
	logic        AVS_WRITE_IN;
	logic [31:0] AVS_WRITEDATA_IN;
	logic [3:0]  AVS_BYTEENABLE_IN;
	logic [31:0] AVS_READDATA_OUT;
	logic        AVS_WAITREQUEST_OUT;
	logic        PAGE_RESP_IN;
	logic        PAGE_SCAN_OUT;
	logic        INQ_SCAN_OUT;
	logic        PAGING_OUT;
	logic        IRQ_OUT;
	logic        bb_answer;
	int          err_total;
	int          checked;
	pts_top #(.SLOT_CYC(8)) u_pts_top (
		.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .AVS_ADDRESS_IN(AVS_ADDRESS_IN),
		.AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
		.AVS_WRITEDATA_IN(AVS_WRITEDATA_IN),
		.AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN),
		.AVS_READDATA_OUT(AVS_READDATA_OUT),
		.AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
		.PAGE_RESP_IN(PAGE_RESP_IN), .PAGE_SCAN_OUT(PAGE_SCAN_OUT),
		.INQ_SCAN_OUT(INQ_SCAN_OUT), .PAGING_OUT(PAGING_OUT), .IRQ_OUT(IRQ_OUT));
	pts_bb_model u_pts_bb_model (.clk_in(CLK_IN), .rst_n_in(RST_N_IN),
		.paging_in(PAGING_OUT), .answer_in(bb_answer), .delay_in(8'h02),
		.resp_out(PAGE_RESP_IN));
	task automatic complete_run();
		if (err_total == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge CLK_IN);
		AVS_ADDRESS_IN   <= a;
		AVS_WRITEDATA_IN <= d;
		AVS_WRITE_IN     <= w;
		AVS_READ_IN      <= !w;
		n = 0;
		do begin
			@(posedge CLK_IN);
			n++;
		end while (AVS_WAITREQUEST_OUT !== 1'b0 && n < 20);
		q = AVS_READDATA_OUT;
		AVS_WRITE_IN <= 1'b0;
		AVS_READ_IN  <= 1'b0;
		if (AVS_WAITREQUEST_OUT !== 1'b0) begin
			err_total++;
			$display("ERROR %0t bus request not answered", $time);
			complete_run();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, q);
	endtask
	task automatic cmd(input logic [9:0] c, input logic [15:0] p,
		output logic [31:0] r);
		pts_pkg::pts_cmd_t w;
		w = '{p, 6'h00, c};
		wr(pts_pkg::OFS_CMD, w);
		rd(pts_pkg::OFS_RESULT, r);
	endtask
	task automatic t_reset();
		logic [31:0] q;
		rd(pts_pkg::OFS_STATE, q);
		check(q, 32'h2000_0000);
		rd(pts_pkg::OFS_PSCAN, q);
		check(q, 32'h0012_0800);
		rd(8'h20, q);
		check(q, 32'h0);
	endtask
	task automatic t_cmds();
		logic [9:0]  c [11] = '{10'h016, 10'h017, 10'h018, 10'h017, 10'h018,
			10'h017, 10'h01a, 10'h019, 10'h01a, 10'h019, 10'h3ff};
		logic [15:0] p [11] = '{16'h0005, 16'h0000, 16'h0000, 16'h0000,
			16'h0003, 16'h0000, 16'h0003, 16'h0000, 16'h0004, 16'h0000,
			16'h0000};
		logic [31:0] e [11] = '{32'h0, 32'h0020_0000, 32'h12, 32'h0020_0000,
			32'h0, 32'h0300, 32'h0, 32'h0300, 32'h12, 32'h0300, 32'h01};
		logic [31:0] q;
		for (int i = 0; i < 11; i++) begin
			cmd(c[i], p[i], q);
			check(q, e[i]);
			rd(pts_pkg::OFS_IRQ_STAT, q);
			check(q & 32'h1, 32'h1);
			wr(pts_pkg::OFS_IRQ_STAT, 32'h1);
		end
	endtask
	task automatic t_irq();
		logic [31:0] q;
		wr(pts_pkg::OFS_IRQ_MASK, 32'h1);
		cmd(pts_pkg::OCF_RD_SCAN, 16'h0, q);
		repeat (2) @(posedge CLK_IN);
		check(IRQ_OUT, 32'h1);
		wr(pts_pkg::OFS_IRQ_STAT, 32'h1);
		repeat (2) @(posedge CLK_IN);
		check(IRQ_OUT, 32'h0);
		cmd(pts_pkg::OCF_RD_PAGE_TO, 16'h0, q);
		wr(pts_pkg::OFS_IRQ_MASK, 32'h0);
		repeat (3) @(posedge CLK_IN);
		check(IRQ_OUT, 32'h0);
		wr(pts_pkg::OFS_IRQ_STAT, 32'h7);
	endtask
	function automatic logic [31:0] near(int c, logic on);
		return on ? ((c >= 276 && c <= 296) ? 1 : 0) : (c == 0 ? 1 : 0);
	endfunction
	task automatic t_scan();
		logic [31:0] q;
		logic [1:0]  en;
		int          pc;
		int          ic;
		wr(pts_pkg::OFS_PSCAN, 32'h0012_0014);
		wr(pts_pkg::OFS_ISCAN, 32'h0012_0014);
		for (int k = 1; k < 5; k++) begin
			en = k[1:0];
			cmd(pts_pkg::OCF_WR_SCAN, {14'h0, en}, q);
			pc = 0;
			ic = 0;
			repeat (320) begin
				@(posedge CLK_IN);
				pc += PAGE_SCAN_OUT;
				ic += INQ_SCAN_OUT;
			end
			check(near(pc, en[1]), 32'h1);
			check(near(ic, en[0]), 32'h1);
		end
	endtask
	task automatic page_len(output int n);
		wr(pts_pkg::OFS_IRQ_STAT, 32'h7);
		wr(pts_pkg::OFS_PAGE_CTL, 32'h1);
		n = 0;
		do begin
			@(posedge CLK_IN);
			n++;
		end while (PAGING_OUT !== 1'b0 && n < 200);
		if (PAGING_OUT !== 1'b0) begin
			err_total++;
			$display("ERROR %0t page attempt never ended", $time);
			complete_run();
		end
	endtask
	task automatic t_page();
		logic [31:0] q;
		int          n;
		page_len(n);
		check((n >= 16 && n <= 28) ? 1 : 0, 32'h1);
		rd(pts_pkg::OFS_IRQ_STAT, q);
		check(q & 32'h6, 32'h2);
		cmd(pts_pkg::OCF_WR_PAGE_TO, 16'h0010, q);
		bb_answer <= 1'b1;
		page_len(n);
		check((n <= 10) ? 1 : 0, 32'h1);
		rd(pts_pkg::OFS_IRQ_STAT, q);
		check(q & 32'h6, 32'h4);
		bb_answer <= 1'b0;
		wr(pts_pkg::OFS_PAGE_CTL, 32'h1);
		repeat (4) @(posedge CLK_IN);
		wr(pts_pkg::OFS_PAGE_CTL, 32'h2);
		repeat (3) @(posedge CLK_IN);
		check(PAGING_OUT, 32'h0);
	endtask
	initial begin
		CLK_IN = 1'b0;
		forever #12.5 CLK_IN = ~CLK_IN;
	end
	initial begin
		RST_N_IN          = 1'b0;
		AVS_ADDRESS_IN    = 8'h00;
		AVS_READ_IN       = 1'b0;
		AVS_WRITE_IN      = 1'b0;
		AVS_WRITEDATA_IN  = 32'h0;
		AVS_BYTEENABLE_IN = 4'hf;
		bb_answer         = 1'b0;
		err_total         = 0;
		checked           = 0;
		repeat (2) @(posedge CLK_IN);
		RST_N_IN <= 1'b1;
		t_reset();
		t_cmds();
		t_irq();
		t_scan();
		t_page();
		complete_run();
	end
endmodule
